// ### hw/qdl_pkg.sv
// shared constants and carrier types for the quad converter serial load logic
package qdl_pkg;
    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int ADDR_BITS = 2;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 14;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 0;
    localparam int NUM_CHAN = 4;
    // ------------------------------------------------------------
    // reset codes and scale
    // ------------------------------------------------------------
    localparam logic [11:0] RESET_CODE_ZERO = 12'h000;
    localparam logic [11:0] RESET_CODE_MID = 12'h800;
    localparam int CODE_SPAN = 4096;
    // ------------------------------------------------------------
    // channel select
    // ------------------------------------------------------------
    localparam logic [1:0] CHAN_A = 2'h0;
    localparam logic [1:0] CHAN_B = 2'h1;
    localparam logic [1:0] CHAN_C = 2'h2;
    localparam logic [1:0] CHAN_D = 2'h3;
    // ------------------------------------------------------------
    // synchroniser idle levels, msb..lsb: clock, select, data,
    // input load, output load, reset code select
    // ------------------------------------------------------------
    localparam logic [5:0] SYNC_IDLE = 6'h36;

    typedef struct packed {
        logic serial_clk;
        logic chip_select_n;
        logic serial_data_in;
    } qdl_serial_type;

    typedef struct packed {
        logic input_latch_load_n;
        logic output_latch_load_n;
        logic reset_code_select;
    } qdl_ctrl_type;
endpackage : qdl_pkg

// ### hw/qdl_load_logic.sv
// quad converter serial load logic: shift register, input latches, output latches
//
// Contract
// - word is 16 bits: 2 address, 2 ignored, 12 code msb first.
// - address 00..11 selects channels A..D; first bit is the high bit.
// - input load low makes only the addressed input latch follow the shifter.
// - output load low makes all output latches follow their input latches.
// - with output load low, addressed output follows once input load falls.
// - reset forces all latches to 000 or 800 by reset code select.
// - reset leaves the shift register contents unchanged.
// - shifter advances one bit on each rising edge of select OR clock.
// - select rising while clock low counts as an extra shift edge.
// - shifting during input load low makes the selected latch follow it.
// - codes are straight binary; output is low ref plus span times code/4096.
// - data on serial data pin; other pins give all control.
`timescale 1ns/1ps
module qdl_load_logic #(
    parameter int WORD_BITS = qdl_pkg::WORD_BITS,
    parameter int CODE_BITS = qdl_pkg::CODE_BITS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hw_reset_n,
    input wire qdl_pkg::qdl_serial_type serial_in,
    input wire qdl_pkg::qdl_ctrl_type ctrl_in,
    output logic [CODE_BITS-1:0] chan_a_code,
    output logic [CODE_BITS-1:0] chan_b_code,
    output logic [CODE_BITS-1:0] chan_c_code,
    output logic [CODE_BITS-1:0] chan_d_code,
    output logic [WORD_BITS-1:0] shift_word
);
    // ------------------------------------------------------------
    // input synchronisers (pins come from outside clk domain)
    // ------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic sclk_s, csn_s, data_s, ild_n_s, old_n_s, rsel_s;
    // resetting to the idle pin levels keeps a fake rising shift clock
    // and a fake open latch out of the first cycles after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= qdl_pkg::SYNC_IDLE;
            sync2_r <= qdl_pkg::SYNC_IDLE;
        end else begin
            sync1_r <= {serial_in.serial_clk, serial_in.chip_select_n,
                        serial_in.serial_data_in, ctrl_in.input_latch_load_n,
                        ctrl_in.output_latch_load_n, ctrl_in.reset_code_select};
            sync2_r <= sync1_r;
        end
    end
    assign {sclk_s, csn_s, data_s, ild_n_s, old_n_s, rsel_s} = sync2_r;

    // ------------------------------------------------------------
    // device reset pin: asserts at once through the flop resets and
    // releases after two clk edges, so the pin never feeds plain logic
    // ------------------------------------------------------------
    logic rst1_r, rst2_r;
    always_ff @(posedge clk or negedge nrst or negedge hw_reset_n) begin
        if (!nrst || !hw_reset_n) begin
            rst1_r <= 1'b0;
            rst2_r <= 1'b0;
        end else begin
            rst1_r <= hw_reset_n;
            rst2_r <= rst1_r;
        end
    end
    logic dev_rst_n;
    assign dev_rst_n = rst2_r;

    // ------------------------------------------------------------
    // shift clock: OR of select and clock, edge found on clk
    // ------------------------------------------------------------
    logic shclk, shclk_d_r, shift_edge;
    assign shclk = csn_s | sclk_s;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shclk_d_r <= 1'b1;
        end else begin
            shclk_d_r <= shclk;
        end
    end
    assign shift_edge = shclk & ~shclk_d_r;

    // no framing: the shifter simply keeps the latest sixteen bits
    logic [WORD_BITS-1:0] shift_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= '0;
        end else if (shift_edge) begin
            shift_r <= {shift_r[WORD_BITS-2:0], data_s};
        end
    end
    // device reset deliberately absent from the shifter
    assign shift_word = shift_r;

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    function automatic logic chan_hit(input logic [1:0] sel, input int idx);
        return sel == 2'(idx);
    endfunction : chan_hit

    // ------------------------------------------------------------
    // latches, modelled as registers updated every clk while open
    // ------------------------------------------------------------
    logic [1:0] addr;
    logic [CODE_BITS-1:0] code;
    logic [CODE_BITS-1:0] rst_code;
    assign addr = shift_r[qdl_pkg::ADDR_MSB:qdl_pkg::ADDR_LSB];
    assign code = shift_r[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB];
    assign rst_code = rsel_s ? qdl_pkg::RESET_CODE_MID : qdl_pkg::RESET_CODE_ZERO;

    logic [CODE_BITS-1:0] in_r [qdl_pkg::NUM_CHAN];
    logic [CODE_BITS-1:0] out_r [qdl_pkg::NUM_CHAN];
    logic [CODE_BITS-1:0] in_nxt [qdl_pkg::NUM_CHAN];

    // the input stage feeds the output stage the same cycle, so with both
    // stages open the addressed output moves on the first cycle
    always_comb begin
        for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
            in_nxt[i] = in_r[i];
            if (!ild_n_s && chan_hit(addr, i)) begin
                in_nxt[i] = code;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
                in_r[i] <= qdl_pkg::RESET_CODE_ZERO;
            end
        end else begin
            for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
                in_r[i] <= dev_rst_n ? in_nxt[i] : rst_code;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
                out_r[i] <= qdl_pkg::RESET_CODE_ZERO;
            end
        end else begin
            for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
                if (!dev_rst_n) begin
                    out_r[i] <= rst_code;
                end else if (!old_n_s) begin
                    out_r[i] <= in_nxt[i];
                end
            end
        end
    end

    assign chan_a_code = out_r[qdl_pkg::CHAN_A];
    assign chan_b_code = out_r[qdl_pkg::CHAN_B];
    assign chan_c_code = out_r[qdl_pkg::CHAN_C];
    assign chan_d_code = out_r[qdl_pkg::CHAN_D];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_edge;
        shclk && !shclk_d_r;
    endsequence

    property p_shift;
        @(posedge clk) disable iff (!nrst)
        s_edge |=> shift_r == {$past(shift_r[WORD_BITS-2:0]), $past(data_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift edge did not advance one bit");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        !(shclk && !shclk_d_r) |=> $stable(shift_r);
    endproperty
    a_hold: assert property (p_hold) else $error("shifter moved without edge");

    property p_rst_keep;
        @(posedge clk) disable iff (!nrst)
        (!dev_rst_n && !shift_edge) |=> $stable(shift_r);
    endproperty
    a_rst_keep: assert property (p_rst_keep) else $error("reset disturbed shifter");

    property p_rst_val;
        @(posedge clk) disable iff (!nrst)
        !dev_rst_n |=> out_r[0] == $past(rst_code) && in_r[3] == $past(rst_code);
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset code not applied");

    property p_in_load;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !ild_n_s && addr == 2'h2) |=> in_r[2] == $past(code);
    endproperty
    a_in_load: assert property (p_in_load) else $error("addressed input latch not loaded");

    property p_in_hold;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && ild_n_s) |=> $stable(in_r[1]);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input latch moved while closed");

    property p_out_hold;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && old_n_s) |=> $stable(out_r[0]) && $stable(out_r[3]);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output latch moved while closed");

    property p_through;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !old_n_s && !ild_n_s && addr == 2'h1) |=> chan_b_code == $past(code);
    endproperty
    a_through: assert property (p_through) else $error("output did not follow load");

    property p_other;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && addr == 2'h0) |=> $stable(in_r[3]);
    endproperty
    a_other: assert property (p_other) else $error("unaddressed latch changed");

    // ------------------------------------------------------------
    // decode assertions, taken straight off the shifter bits so that a
    // wrong address slice in the latch logic cannot hide behind itself
    // ------------------------------------------------------------
    property p_addr_a;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !ild_n_s && !shift_r[qdl_pkg::ADDR_MSB] && !shift_r[qdl_pkg::ADDR_LSB])
            |=> in_r[0] == $past(shift_r[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB]);
    endproperty
    a_addr_a: assert property (p_addr_a) else $error("address 00 missed channel A");

    property p_addr_c;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !ild_n_s && shift_r[qdl_pkg::ADDR_MSB] && !shift_r[qdl_pkg::ADDR_LSB])
            |=> in_r[2] == $past(shift_r[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB]);
    endproperty
    a_addr_c: assert property (p_addr_c) else $error("address 10 missed channel C");

    property p_addr_d;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !ild_n_s && shift_r[qdl_pkg::ADDR_MSB] && shift_r[qdl_pkg::ADDR_LSB])
            |=> in_r[3] == $past(shift_r[qdl_pkg::CODE_MSB:qdl_pkg::CODE_LSB]);
    endproperty
    a_addr_d: assert property (p_addr_d) else $error("address 11 missed channel D");

    // with the input load open every new shifter value is taken at once,
    // so a word shifted through an open latch also moves its selection
    property p_follow;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !ild_n_s) |=> in_r[$past(addr)] == $past(code);
    endproperty
    a_follow: assert property (p_follow) else $error("open input latch lagged shifter");

    property p_in_others;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && addr != qdl_pkg::CHAN_A) |=> $stable(in_r[0]);
    endproperty
    a_in_others: assert property (p_in_others) else $error("channel A moved unaddressed");

    property p_out_follow;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && !old_n_s && ild_n_s)
            |=> out_r[2] == $past(in_r[2]) && chan_d_code == $past(in_r[3]);
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("open output latch lagged");

    property p_out_hold_mid;
        @(posedge clk) disable iff (!nrst)
        (dev_rst_n && old_n_s) |=> $stable(chan_b_code) && $stable(chan_c_code);
    endproperty
    a_out_hold_mid: assert property (p_out_hold_mid) else $error("closed output moved");

    sequence s_both_open;
        dev_rst_n && !old_n_s && !ild_n_s;
    endsequence
    property p_through_any;
        @(posedge clk) disable iff (!nrst)
        s_both_open |=> out_r[$past(addr)] == $past(code);
    endproperty
    a_through_any: assert property (p_through_any) else $error("output not passed through");

    // ------------------------------------------------------------
    // reset code assertions
    // ------------------------------------------------------------
    property p_rst_mid;
        @(posedge clk) disable iff (!nrst)
        (!dev_rst_n && rsel_s) |=> chan_a_code == qdl_pkg::RESET_CODE_MID
            && chan_b_code == qdl_pkg::RESET_CODE_MID && chan_c_code == qdl_pkg::RESET_CODE_MID
            && chan_d_code == qdl_pkg::RESET_CODE_MID;
    endproperty
    a_rst_mid: assert property (p_rst_mid) else $error("outputs not reset to mid scale");

    property p_rst_zero;
        @(posedge clk) disable iff (!nrst)
        (!dev_rst_n && !rsel_s) |=> in_r[0] == qdl_pkg::RESET_CODE_ZERO
            && in_r[1] == qdl_pkg::RESET_CODE_ZERO && in_r[2] == qdl_pkg::RESET_CODE_ZERO
            && in_r[3] == qdl_pkg::RESET_CODE_ZERO;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("input latches not reset to zero");

    // select rising over a low clock is a rising edge of the or gate
    sequence s_cs_rise;
        $rose(csn_s) && !sclk_s && !$past(sclk_s);
    endsequence
    property p_extra;
        @(posedge clk) disable iff (!nrst)
        s_cs_rise |-> shift_edge;
    endproperty
    a_extra: assert property (p_extra) else $error("select rise gave no shift edge");
endmodule : qdl_load_logic

// ### tb/qdl_host_model.sv
// host model that shifts words into the load logic through its pins
`timescale 1ns/1ps
module qdl_host_model (
    input wire logic clk,
    output qdl_pkg::qdl_serial_type serial
);
    initial serial = 3'b110;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // -----------------------------------------
    // mode 0 clocks with serial_clk, 1 with chip select, 2 ends with clock low
    // -----------------------------------------
    task automatic send(input logic [15:0] w, input int mode);
        if (mode == 1) serial.serial_clk = 1'b0;
        step(4);
        for (int i = 15; i >= 0; i--) begin
            if (mode == 1) serial.chip_select_n = 1'b0;
            else {serial.chip_select_n, serial.serial_clk} = 2'b00;
            serial.serial_data_in = w[i];
            step(4);
            if (mode == 1) serial.chip_select_n = 1'b1;
            else serial.serial_clk = 1'b1;
            step(4);
        end
        if (mode == 2) serial.serial_clk = 1'b0;
        step(4);
        serial.chip_select_n = 1'b1;
        step(4);
        serial.serial_clk = 1'b1;
        // released data line shows the inverse, no pull on it
        serial.serial_data_in = ~w[0];
    endtask : send
endmodule : qdl_host_model

// ### tb/test_qdl_load_logic.sv
// self-checking bench for the quad converter serial load logic
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_qdl_load_logic;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hw_reset_n = 1'b1;
    qdl_pkg::qdl_serial_type serial;
    qdl_pkg::qdl_ctrl_type ctrl = 3'b110;
    logic [11:0] code [4];
    logic [11:0] exp_out [4];
    logic [11:0] vals [4] = '{12'hFFF, 12'h001, 12'h800, 12'h5A3};
    logic [15:0] shift_word;
    logic [15:0] last;
    int fail_count = 0;
    int checked = 0;
    always #10 clk = ~clk;
    qdl_host_model qdl_host_model_inst (.clk(clk), .serial(serial));
    qdl_load_logic qdl_load_logic_inst (.clk(clk), .nrst(nrst), .hw_reset_n(hw_reset_n),
        .serial_in(serial), .ctrl_in(ctrl), .chan_a_code(code[0]), .chan_b_code(code[1]),
        .chan_c_code(code[2]), .chan_d_code(code[3]), .shift_word(shift_word));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check_outs();
        for (int c = 0; c < 4; c++) `CHK(code[c], exp_out[c])
    endtask : check_outs
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic test_channels();
        for (int c = 0; c < 4; c++) begin
            last = {c[1:0], 2'b11, vals[c]};
            qdl_host_model_inst.send(last, c % 2);
            `CHK(shift_word, last)
            ctrl.input_latch_load_n = 1'b0;
            step(4);
            ctrl.input_latch_load_n = 1'b1;
            step(4);
            check_outs();
        end
        ctrl.output_latch_load_n = 1'b0;
        step(4);
        ctrl.output_latch_load_n = 1'b1;
        step(4);
        exp_out = vals;
        check_outs();
    endtask : test_channels
    task automatic test_transparent();
        ctrl.output_latch_load_n = 1'b0;
        last = 16'h43C7;
        qdl_host_model_inst.send(last, 0);
        check_outs();
        ctrl.input_latch_load_n = 1'b0;
        step(4);
        exp_out[1] = 12'h3C7;
        check_outs();
        ctrl = 3'b110;
        step(4);
    endtask : test_transparent
    task automatic test_extra_edge();
        // ending with the clock low costs one more shift of the last bit
        qdl_host_model_inst.send(16'hC00F, 2);
        last = 16'h801F;
        `CHK(shift_word, last)
    endtask : test_extra_edge
    task automatic test_hw_reset();
        for (int s = 1; s >= 0; s--) begin
            ctrl.reset_code_select = s[0];
            step(4);
            hw_reset_n = 1'b0;
            step(4);
            hw_reset_n = 1'b1;
            step(4);
            for (int c = 0; c < 4; c++)
                exp_out[c] = s ? qdl_pkg::RESET_CODE_MID : qdl_pkg::RESET_CODE_ZERO;
            check_outs();
            `CHK(shift_word, last)
        end
    endtask : test_hw_reset
    task automatic conclude();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        step(2);
        nrst = 1'b1;
        step(3);
        for (int c = 0; c < 4; c++) exp_out[c] = 12'h000;
        check_outs();
        `CHK(shift_word, 16'h0000)
        test_channels();
        test_transparent();
        test_extra_edge();
        test_hw_reset();
        conclude();
    end
    initial begin
        #100us;
        fail_count++;
        conclude();
    end
endmodule : test_qdl_load_logic
